/* File: logic/cppc_top.sv */
/*
 * Power path controller: converter mode, bypass and system targets,
 * battery switch, safety timer, thermal foldback, overcurrent, input
 * validation and its interrupt, with an APB register slave.
 * Assumes analog comparators and current sensing arrive as synchronous
 * digital inputs and the regulation loops act on the targets driven here.
 */
`timescale 1ns/100ps
module cppc_top
	import cppc_pkg::*;
#(
	parameter logic [37:0] HOUR_CYCLES = 38'(longint'(HOUR_S) * longint'(CLK_HZ))
) (
	// clock and reset
	input  wire logic        CLK,
	input  wire logic        RESETN,
	// apb slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// analog status
	input  wire logic        IN_ABOVE_UVLO,
	input  wire logic        IN_BELOW_OVLO,
	input  wire logic        IN_ABOVE_SYS,
	input  wire logic        IN_DROPOUT,
	input  wire logic        BATTERY_NODE_DET_LOW,
	input  wire logic        BATTERY_NODE_BELOW_MINSYS,
	input  wire logic        CHARGE_DONE,
	input  wire logic [12:0] BATTERY_NODE_CURRENT_MA,
	input  wire logic [12:0] LOAD_CURRENT_MA,
	input  wire logic [7:0]  DIE_TEMP_C,
	input  wire logic        FG_SAMPLE,
	input  wire logic        FG_CONTINUOUS,
	// power path controls
	output logic      [1:0]  CONVERTER_STATE,
	output logic      [12:0] BYP_TARGET_MV,
	output logic             BYP_FOLLOW_INPUT,
	output logic             BYP_TIE_SYS,
	output logic      [12:0] SYS_TARGET_MV,
	output logic      [1:0]  BATTERY_SWITCH,
	output logic      [12:0] CHARGE_TARGET_MA,
	output logic      [12:0] INPUT_LIMIT_MA,
	output logic      [7:0]  FOLDBACK_TEMP_C,
	// interrupt pin, open drain
	output logic             INTERRUPT_OUT_N,
	output logic             INTERRUPT_OE
);
	// control registers
	logic [3:0]  mode_reg;
	logic        dpd_reg;
	logic [2:0]  tmr_sel_reg;
	logic [1:0]  temp_sel_reg;
	logic [2:0]  ocp_sel_reg;
	logic [6:0]  ilim_reg;
	logic [5:0]  chg_reg;
	logic [5:0]  cv_reg;
	logic [12:0] byp_mv_reg;
	logic [12:0] minsys_reg;
	logic [1:0]  irq_reg;
	logic [1:0]  mask_reg;
	// internal state
	logic        valid_reg;
	logic [37:0] tick_reg;
	logic [4:0]  hours_reg;
	logic        tfault_reg;
	logic [12:0] backoff_reg;
	logic        ocp_prev_reg;
	cppc_mode_t  mode;

	// bus decode
	wire         setup   = PSEL & ~PENABLE;
	wire         wr      = PSEL & PENABLE & PREADY & PWRITE;
	wire         hit     = (PADDR == OFS_CTRL) | (PADDR == OFS_LIMITS) |
	                       (PADDR == OFS_VOLTS) | (PADDR == OFS_STATUS) |
	                       (PADDR == OFS_IRQ) | (PADDR == OFS_MASK);
	wire         wr_ctrl = wr & (PADDR == OFS_CTRL);
	wire         wr_lim  = wr & (PADDR == OFS_LIMITS);
	wire         wr_volt = wr & (PADDR == OFS_VOLTS);
	wire         wr_irq  = wr & (PADDR == OFS_IRQ);
	wire         wr_mask = wr & (PADDR == OFS_MASK);

	// input qualification and presence
	wire         valid   = IN_ABOVE_UVLO & IN_BELOW_OVLO & IN_ABOVE_SYS;
	wire [2:0]   details = {IN_ABOVE_SYS, IN_BELOW_OVLO, IN_ABOVE_UVLO};
	wire         present = BATTERY_NODE_DET_LOW;
	// unknown mode codes are treated as converter off
	assign mode = cppc_mode_t'(mode_reg);
	wire         is_boost = (mode == MD_BOOST) | (mode == MD_OTG_A) | (mode == MD_OTG_B);
	wire         is_off   = ~is_boost & (mode != MD_BUCK) & (mode != MD_BUCK_CHG);
	wire         charging = (mode == MD_BUCK_CHG) & valid & present &
	                        ~tfault_reg & ~CHARGE_DONE;

	// safety timer limit in hours
	wire [4:0]   tmr_lim  = TMR_BASE_H + {1'b0, tmr_sel_reg, 1'b0};
	wire         tmr_on   = (tmr_sel_reg != TMR_OFF);
	wire         hour_end = (tick_reg == HOUR_CYCLES - 38'h1);

	// die temperature threshold select
	function automatic logic [7:0] temp_thr(input logic [1:0] sel);
		unique case (sel)
			2'h0: temp_thr = TEMP_70;
			2'h1: temp_thr = TEMP_85;
			2'h2: temp_thr = TEMP_100;
			2'h3: temp_thr = TEMP_115;
		endcase
	endfunction
	wire [7:0]   thr      = temp_thr(temp_sel_reg);
	wire         foldback = DIE_TEMP_C >= thr;

	// overcurrent compare
	wire [12:0]  ocp_ma   = OCP_BASE_MA + 13'(OCP_STEP_MA * 13'(ocp_sel_reg - 3'h1));
	wire         ocp_hit  = (ocp_sel_reg != OCP_OFF) & (BATTERY_NODE_CURRENT_MA > ocp_ma);

	// input budget: bypass and system first, battery gets the rest
	wire [12:0]  ilim_ma  = 13'((20'(ilim_reg) * 20'd100) / 20'd3);
	wire         supplement = LOAD_CURRENT_MA > ilim_ma;
	wire [12:0]  headroom = supplement ? 13'h0 : ilim_ma - LOAD_CURRENT_MA;
	wire [12:0]  chg_set  = 13'(CHG_STEP_MA * 13'(chg_reg));
	wire [12:0]  chg_fb   = foldback ? (chg_set >> 1) : chg_set;
	wire [12:0]  chg_drop = (backoff_reg >= chg_fb) ? 13'h0 : chg_fb - backoff_reg;
	wire [12:0]  chg_min  = (chg_drop < headroom) ? chg_drop : headroom;

	// dropout backoff walks the charge current down and back up
	wire [12:0]  backoff_next = IN_DROPOUT ?
	                            ((backoff_reg >= chg_fb) ? backoff_reg : backoff_reg + 13'h1) :
	                            ((backoff_reg == 13'h0) ? 13'h0 : backoff_reg - 13'h1);

	// battery switch selection
	cppc_sw_t    sw_next;
	always_comb begin
		if (dpd_reg)
			sw_next = SW_OPEN;
		else if (is_boost)
			sw_next = SW_CLOSED;
		else if (supplement & ~is_off)
			sw_next = (FG_CONTINUOUS & (BATTERY_NODE_CURRENT_MA < FG_OPEN_MA)) ? SW_OPEN :
			          (FG_SAMPLE | FG_CONTINUOUS) ? SW_CLOSED : SW_OPEN;
		else if (charging)
			sw_next = BATTERY_NODE_BELOW_MINSYS ? SW_LINEAR : SW_CLOSED;
		else if (is_off)
			sw_next = SW_CLOSED;
		else
			sw_next = SW_OPEN;
	end

	// bypass and system targets
	wire [12:0]  cv_mv    = CV_BASE_MV + 13'(CV_STEP_MV * 13'(cv_reg));
	wire [12:0]  byp_next = (mode == MD_BOOST) ? byp_mv_reg :
	                        is_boost ? OTG_BYP_MV : 13'h0;
	wire         follow_next = ~is_boost & valid;
	wire         tie_next    = is_off & ~valid;
	wire [12:0]  sys_next    = (is_boost | is_off) ? 13'h0 :
	                           charging ? minsys_reg : cv_mv;
	wire [1:0]   conv_next   = is_boost ? CV_BOOST : is_off ? CV_OFF : CV_BUCK;

	// interrupt sources, set wins over a same-cycle clear
	wire [1:0]   irq_set  = {ocp_hit & ~ocp_prev_reg, valid != valid_reg};
	wire [1:0]   irq_clr  = wr_irq ? PWDATA[1:0] : 2'h0;
	wire [1:0]   irq_next = irq_set | (irq_reg & ~irq_clr);
	// pin uses the mask being written, so pin and pending bits never disagree
	wire [1:0]   mask_next = wr_mask ? PWDATA[1:0] : mask_reg;
	wire         int_next = |(irq_next & ~mask_next);

	// read mux
	wire [31:0]  rd_status = {21'h0, BATTERY_SWITCH, foldback, supplement, tfault_reg,
	                          charging, present, details, valid};
	wire [31:0]  rd_data =
		(PADDR == OFS_CTRL)   ? {13'h0, ocp_sel_reg, 2'h0, temp_sel_reg, 1'b0,
		                         tmr_sel_reg, 3'h0, dpd_reg, mode_reg} :
		(PADDR == OFS_LIMITS) ? {10'h0, cv_reg, 2'h0, chg_reg, 1'b0, ilim_reg} :
		(PADDR == OFS_VOLTS)  ? {3'h0, minsys_reg, 3'h0, byp_mv_reg} :
		(PADDR == OFS_STATUS) ? rd_status :
		(PADDR == OFS_IRQ)    ? {30'h0, irq_reg} :
		(PADDR == OFS_MASK)   ? {30'h0, mask_reg} : 32'h0;

	// apb answer: ready in the access cycle, data caught at setup
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PREADY  <= 1'b0;
			PRDATA  <= 32'h0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup;
			PRDATA  <= setup ? rd_data : PRDATA;
			PSLVERR <= setup & ~hit;
		end
	end

	// software writable settings, limit values over range saturate
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_reg     <= RST_MODE;
			dpd_reg      <= 1'b0;
			tmr_sel_reg  <= RST_TIMER;
			temp_sel_reg <= RST_TEMP;
			ocp_sel_reg  <= RST_OCP;
		end else if (wr_ctrl) begin
			mode_reg     <= PWDATA[3:0];
			dpd_reg      <= PWDATA[4];
			tmr_sel_reg  <= PWDATA[10:8];
			temp_sel_reg <= PWDATA[13:12];
			ocp_sel_reg  <= PWDATA[18:16];
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ilim_reg   <= RST_ILIM;
			chg_reg    <= RST_CHG;
			cv_reg     <= RST_CV;
			byp_mv_reg <= RST_BYP_MV;
			minsys_reg <= RST_MINSYS_MV;
		end else begin
			if (wr_lim) begin
				ilim_reg <= (PWDATA[6:0] > ILIM_MAX) ? ILIM_MAX : PWDATA[6:0];
				chg_reg  <= (PWDATA[13:8] > CHG_MAX) ? CHG_MAX : PWDATA[13:8];
				cv_reg   <= (PWDATA[21:16] > CV_MAX) ? CV_MAX : PWDATA[21:16];
			end
			if (wr_volt) begin
				byp_mv_reg <= PWDATA[12:0];
				minsys_reg <= PWDATA[28:16];
			end
		end
	end

	// interrupt state and pin
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_reg         <= 2'h0;
			mask_reg        <= RST_MASK;
			valid_reg       <= 1'b0;
			ocp_prev_reg    <= 1'b0;
			INTERRUPT_OUT_N <= 1'b1;
			INTERRUPT_OE    <= 1'b0;
		end else begin
			irq_reg         <= irq_next;
			mask_reg        <= mask_next;
			valid_reg       <= valid;
			ocp_prev_reg    <= ocp_hit;
			INTERRUPT_OUT_N <= ~int_next;
			INTERRUPT_OE    <= int_next;
		end
	end

	// safety timer; fault holds until charge mode or input drops
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tick_reg   <= 38'h0;
			hours_reg  <= 5'h0;
			tfault_reg <= 1'b0;
		end else if ((mode != MD_BUCK_CHG) | ~valid) begin
			tick_reg   <= 38'h0;
			hours_reg  <= 5'h0;
			tfault_reg <= 1'b0;
		end else if (charging & tmr_on) begin
			tick_reg   <= hour_end ? 38'h0 : tick_reg + 38'h1;
			hours_reg  <= hour_end ? hours_reg + 5'h1 : hours_reg;
			tfault_reg <= hour_end & (hours_reg + 5'h1 >= tmr_lim);
		end
	end

	// registered power path outputs
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			backoff_reg      <= 13'h0;
			CONVERTER_STATE  <= CV_OFF;
			BYP_TARGET_MV    <= 13'h0;
			BYP_FOLLOW_INPUT <= 1'b0;
			BYP_TIE_SYS      <= 1'b0;
			SYS_TARGET_MV    <= 13'h0;
			BATTERY_SWITCH   <= SW_OPEN;
			CHARGE_TARGET_MA <= 13'h0;
			INPUT_LIMIT_MA   <= 13'h0;
			FOLDBACK_TEMP_C  <= 8'h0;
		end else begin
			backoff_reg      <= backoff_next;
			CONVERTER_STATE  <= conv_next;
			BYP_TARGET_MV    <= byp_next;
			BYP_FOLLOW_INPUT <= follow_next;
			BYP_TIE_SYS      <= tie_next;
			SYS_TARGET_MV    <= sys_next;
			BATTERY_SWITCH   <= sw_next;
			CHARGE_TARGET_MA <= charging ? chg_min : 13'h0;
			INPUT_LIMIT_MA   <= ilim_ma;
			FOLDBACK_TEMP_C  <= thr;
		end
	end

	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence dpd_written;
		wr_ctrl && PWDATA[4];
	endsequence
	sequence switch_open2;
		BATTERY_SWITCH == SW_OPEN [*2];
	endsequence
	dpd_opens_a: assert property (dpd_written |=> ##1 switch_open2)
		else $error("discharge disable did not open the switch");
	boost_closed_a: assert property (is_boost && !dpd_reg |=> BATTERY_SWITCH == SW_CLOSED)
		else $error("boost mode without closed battery switch");
	otg_byp_a: assert property ((mode == MD_OTG_A || mode == MD_OTG_B) |=>
		BYP_TARGET_MV == OTG_BYP_MV)
		else $error("otg bypass target not fixed");
	boost_byp_a: assert property (mode == MD_BOOST |=> BYP_TARGET_MV == $past(byp_mv_reg))
		else $error("boost bypass target wrong");
	input_irq_a: assert property (valid != $past(valid) |=> irq_reg[0])
		else $error("input change not flagged");
	int_pin_a: assert property ((irq_reg & ~mask_reg) != 2'h0 |-> !INTERRUPT_OUT_N)
		else $error("interrupt pin not asserted");
	ocp_irq_a: assert property ($rose(ocp_hit) |=> irq_reg[1])
		else $error("overcurrent not flagged");
	absent_nochg_a: assert property (!present |=> CHARGE_TARGET_MA == 13'h0)
		else $error("charging without battery");
	tie_sys_a: assert property (is_off && !valid |=> BYP_TIE_SYS && !BYP_FOLLOW_INPUT)
		else $error("bypass not tied to system");
	buck_sys_a: assert property (mode == MD_BUCK && !dpd_reg && !supplement |=>
		BATTERY_SWITCH == SW_OPEN && SYS_TARGET_MV == $past(cv_mv))
		else $error("buck idle targets wrong");
	ilim_rst_a: assert property ($rose(RESETN) |-> ##1 INPUT_LIMIT_MA == 13'h01F4)
		else $error("input limit default not 500 mA");
	// pin released whenever nothing unmasked is pending
	int_idle_a: assert property ((irq_reg & ~mask_reg) == 2'h0 |->
		INTERRUPT_OUT_N && !INTERRUPT_OE)
		else $error("interrupt pin driven with nothing pending");
	buck_conv_a: assert property ((mode == MD_BUCK || mode == MD_BUCK_CHG) |=>
		CONVERTER_STATE == CV_BUCK)
		else $error("buck mode without buck converter state");
	follow_in_a: assert property (!is_boost && valid |=>
		BYP_FOLLOW_INPUT && !BYP_TIE_SYS)
		else $error("bypass not following valid input");
	linear_sw_a: assert property (charging && BATTERY_NODE_BELOW_MINSYS &&
		!dpd_reg && !supplement |=> BATTERY_SWITCH == SW_LINEAR)
		else $error("low battery charging without linear switch");
	chg_room_a: assert property (charging |=>
		CHARGE_TARGET_MA <= $past(headroom))
		else $error("charge target above input headroom");
	fg_close_a: assert property (supplement && !is_off && !is_boost && !dpd_reg &&
		FG_SAMPLE && !FG_CONTINUOUS |=> BATTERY_SWITCH == SW_CLOSED)
		else $error("gauge sample in supplement left switch open");
	fg_open_a: assert property (supplement && !is_off && !is_boost && !dpd_reg &&
		FG_CONTINUOUS && BATTERY_NODE_CURRENT_MA < FG_OPEN_MA |=> BATTERY_SWITCH == SW_OPEN)
		else $error("continuous sampling at low current left switch closed");
endmodule

/* File: logic/cppc_pkg.sv */
/*
 * Constants, register map and types for the charger power path control.
 * Assumes a 40 MHz core clock and an APB master with 32-bit data.
 */
package cppc_pkg;
	localparam int unsigned CLK_HZ         = 40000000;
	localparam int unsigned HOUR_S         = 3600;
	// register byte offsets
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_LIMITS     = 8'h04;
	localparam logic [7:0]  OFS_VOLTS      = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0C;
	localparam logic [7:0]  OFS_IRQ        = 8'h10;
	localparam logic [7:0]  OFS_MASK       = 8'h14;
	// reset values
	localparam logic [3:0]  RST_MODE       = 4'h0;
	localparam logic [2:0]  RST_TIMER      = 3'h3;
	localparam logic [1:0]  RST_TEMP       = 2'h3;
	localparam logic [2:0]  RST_OCP        = 3'h7;
	localparam logic [6:0]  RST_ILIM       = 7'h0F;
	localparam logic [5:0]  RST_CHG        = 6'h0A;
	localparam logic [5:0]  RST_CV         = 6'h18;
	localparam logic [12:0] RST_BYP_MV     = 13'h1388;
	localparam logic [12:0] RST_MINSYS_MV  = 13'h0E10;
	localparam logic [1:0]  RST_MASK       = 2'h0;
	// setting scales
	localparam logic [12:0] OTG_BYP_MV     = 13'h13EC;
	localparam logic [12:0] CV_BASE_MV     = 13'h0E29;
	localparam logic [12:0] CV_STEP_MV     = 13'h0019;
	localparam logic [5:0]  CV_MAX         = 6'h2B;
	localparam logic [12:0] CHG_STEP_MA    = 13'h0032;
	localparam logic [5:0]  CHG_MAX        = 6'h3C;
	localparam logic [6:0]  ILIM_MAX       = 7'h5A;
	localparam logic [12:0] OCP_BASE_MA    = 13'h0BB8;
	localparam logic [12:0] OCP_STEP_MA    = 13'h00FA;
	localparam logic [2:0]  OCP_OFF        = 3'h0;
	localparam logic [12:0] FG_OPEN_MA     = 13'h0028;
	localparam logic [4:0]  TMR_BASE_H     = 5'h04;
	localparam logic [2:0]  TMR_OFF        = 3'h7;
	localparam logic [7:0]  TEMP_70        = 8'h46;
	localparam logic [7:0]  TEMP_85        = 8'h55;
	localparam logic [7:0]  TEMP_100       = 8'h64;
	localparam logic [7:0]  TEMP_115       = 8'h73;

	typedef enum logic [3:0] {
		MD_OFF      = 4'h0,
		MD_BUCK     = 4'h4,
		MD_BUCK_CHG = 4'h5,
		MD_BOOST    = 4'h8,
		MD_OTG_A    = 4'h9,
		MD_OTG_B    = 4'hA
	} cppc_mode_t;

	typedef enum logic [1:0] {
		SW_OPEN    = 2'b00,
		SW_LINEAR  = 2'b01,
		SW_CLOSED  = 2'b10
	} cppc_sw_t;

	typedef enum logic [1:0] {
		CV_OFF     = 2'b00,
		CV_BUCK    = 2'b01,
		CV_BOOST   = 2'b10
	} cppc_conv_t;
endpackage

/* File: test/cppc_far_model.sv */
/*
 * Far-side model: adapter input, battery and detect pin, as comparator levels.
 * Assumes the bench sets voltages in mV just after a rising clock edge.
 */
`timescale 1ns/100ps
module cppc_far_model #(
	parameter int UVLO_MV   = 3900,
	parameter int OVLO_MV   = 14000,
	parameter int MARGIN_MV = 200,
	parameter int MINSYS_MV = 3600
) (
	// commanded conditions
	input  wire logic [13:0] adapter_mv,
	input  wire logic [13:0] sys_mv,
	input  wire logic [13:0] battery_node_mv,
	input  wire logic        battery_node_present,
	// comparator levels toward the controller
	output logic             above_uvlo,
	output logic             below_ovlo,
	output logic             above_sys,
	output logic             dropout,
	output logic             det_low,
	output logic             below_minsys
);
	// adapter comparators, all three must agree for a valid input
	assign above_uvlo = adapter_mv > UVLO_MV;
	assign below_ovlo = adapter_mv < OVLO_MV;
	assign above_sys  = adapter_mv > sys_mv + MARGIN_MV;
	// a sagging source flags dropout; zero means unplugged
	assign dropout    = adapter_mv != 0 && adapter_mv < 4300;
	// detect pin pulled low only by a fitted pack
	assign det_low      = battery_node_present;
	assign below_minsys = battery_node_mv < MINSYS_MV;
endmodule

/* File: test/cppc_tb_top.sv */
/*
 * Self-checking bench for the power path controller, with a reference model.
 * Assumes an APB slave that raises PREADY and a far-side model driving the comparators.
 */
`timescale 1ns/100ps
module cppc_tb_top
	import cppc_pkg::*;
;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rdat;
	logic [12:0] ibat = 13'h0, iload = 13'h0;
	logic        fg_s = 1'b0, fg_c = 1'b0, present = 1'b1, rerr, done = 1'b0;
	logic [7:0]  dtemp = 8'h19;
	logic [13:0] ad_mv = 14'h0, bat_mv = 14'h0F3C;
	wire  [31:0] prdata;
	wire         pready, pslverr, uv, ov, asys, drop, det, blo, int_n, int_oe;
	wire  [1:0]  conv, sw;
	wire  [12:0] byp_t, sys_t, chg_t, ilim;
	wire  [7:0]  fold;
	wire         follow, tie;
	wire         int_pin = int_oe ? int_n : 1'b1; // pulled up when released
	int          n_fail = 0, compares = 0, seed = 44545, bypass_node = 5000, thr, c, ld, e;
	int          modes[6] = '{0, 4, 5, 8, 9, 10};
	int          ocps[4] = '{0, 1, 7, 3};

	// 40 MHz clock
	always #12.5 clk = ~clk;

	cppc_far_model u_far (.adapter_mv(ad_mv), .sys_mv(14'h0ED8), .battery_node_mv(bat_mv),
		.battery_node_present(present), .above_uvlo(uv), .below_ovlo(ov), .above_sys(asys),
		.dropout(drop), .det_low(det), .below_minsys(blo));

	// hour shortened to 10 cycles so the safety timer fits the run
	cppc_top #(.HOUR_CYCLES(38'h0A)) u_dut (.CLK(clk), .RESETN(rstn), .PSEL(psel),
		.PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .IN_ABOVE_UVLO(uv), .IN_BELOW_OVLO(ov),
		.IN_ABOVE_SYS(asys), .IN_DROPOUT(drop), .BATTERY_NODE_DET_LOW(det),
		.BATTERY_NODE_BELOW_MINSYS(blo), .CHARGE_DONE(done), .BATTERY_NODE_CURRENT_MA(ibat),
		.LOAD_CURRENT_MA(iload), .DIE_TEMP_C(dtemp), .FG_SAMPLE(fg_s),
		.FG_CONTINUOUS(fg_c), .CONVERTER_STATE(conv), .BYP_TARGET_MV(byp_t),
		.BYP_FOLLOW_INPUT(follow), .BYP_TIE_SYS(tie), .SYS_TARGET_MV(sys_t),
		.BATTERY_SWITCH(sw), .CHARGE_TARGET_MA(chg_t), .INPUT_LIMIT_MA(ilim),
		.FOLDBACK_TEMP_C(fold), .INTERRUPT_OUT_N(int_n), .INTERRUPT_OE(int_oe));

	task automatic results;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// one transfer; an idle edge first keeps each signal to one write per step
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// no cycle count assumed; a hung slave is left to the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// reference of the power path for settled, uncharged-fault-free cases
	task automatic chk_path(input int m, input int v, input int lo);
		chk("conv", (m == 0) ? 0 : (m < 8) ? 1 : 2, conv);
		chk("byp", (m == 8) ? bypass_node : (m > 8) ? 5100 : 0, byp_t);
		chk("follow", (m < 8) && v, follow);
		chk("tie", m == 0 && !v, tie);
		chk("sys", (m == 4) ? 4225 : (m == 5) ? 3600 : 0, sys_t);
		chk("switch", (m == 4) ? 0 : (m == 5 && lo) ? 1 : 2, sw);
	endtask

	initial begin
		tick(8);
		rstn <= 1'b1;
		tick(3);
		chk("ilim", 500, ilim);
		chk("fold", 115, fold);
		apb(1'b0, OFS_CTRL, 0);
		chk("ctrl", 32'h00073300, rdat);
		chk("slverr ok", 0, rerr);
		apb(1'b0, 8'h18, 0);
		chk("slverr", 1, rerr);
		chk_path(0, 0, 0);
		// plug a valid adapter: status change pulls the pin low
		ad_mv <= 14'h1388;
		tick(4);
		apb(1'b0, OFS_STATUS, 0);
		chk("status", 32'h1F, rdat & 32'h1F);
		chk("pin", 0, int_pin);
		apb(1'b1, OFS_MASK, 1);
		tick(3);
		chk("masked", 1, int_pin);
		apb(1'b1, OFS_MASK, 0);
		apb(1'b1, OFS_IRQ, 1);
		tick(3);
		chk("cleared", 1, int_pin);
		ad_mv <= 14'h3A98;
		tick(4);
		apb(1'b0, OFS_STATUS, 0);
		chk("ovlo", 32'hA, rdat & 32'hF);
		apb(1'b0, OFS_IRQ, 0);
		chk("irq", 1, rdat & 1);
		ad_mv <= 14'h1388;
		tick(4);
		apb(1'b1, OFS_IRQ, 3);
		foreach (modes[i]) begin
			bat_mv <= ($random(seed) & 1) ? 14'h0D48 : 14'h0F3C;
			bypass_node = 3000 + ({$random(seed)} % 2801);
			apb(1'b1, OFS_VOLTS, (3600 << 16) | bypass_node);
			apb(1'b1, OFS_CTRL, 32'h00073300 | modes[i]);
			tick(3);
			chk_path(modes[i], 1, bat_mv < 3600);
		end
		apb(1'b1, OFS_CTRL, 32'h00073318);
		tick(3);
		chk("dpd", 0, sw);
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, OFS_CTRL, 32'h00070300 | (s << 12));
			tick(3);
			chk("fold", 70 + 15 * s, fold);
		end
		for (int k = 0; k < 3; k++) begin
			c = k ? {$random(seed)} % 91 : 90;
			apb(1'b1, OFS_LIMITS, 32'h00180A00 | c);
			tick(3);
			chk("ilim", c * 100 / 3, ilim);
		end
		apb(1'b1, OFS_LIMITS, 32'h00180A0F);
		foreach (ocps[i]) begin
			thr = ocps[i] ? 3000 + 250 * (ocps[i] - 1) : 4600;
			apb(1'b1, OFS_CTRL, 32'h00003300 | (ocps[i] << 16));
			ibat <= 13'(thr);
			tick(3);
			apb(1'b0, OFS_IRQ, 0);
			chk("ocp at", 0, rdat & 2);
			ibat <= 13'(thr + 1);
			tick(3);
			apb(1'b0, OFS_IRQ, 0);
			chk("ocp over", ocps[i] ? 2 : 0, rdat & 2);
			apb(1'b1, OFS_IRQ, 3);
			ibat <= 13'h0064;
		end
		// supplement: load above the 500 mA input limit
		apb(1'b1, OFS_CTRL, 32'h00073304);
		iload <= 13'h0258;
		fg_s <= 1'b1;
		tick(3);
		chk("fg sample", 2, sw);
		fg_s <= 1'b0;
		fg_c <= 1'b1;
		ibat <= 13'h001E;
		tick(3);
		chk("fg cont", 0, sw);
		fg_c <= 1'b0;
		iload <= 13'h0;
		present <= 1'b0;
		apb(1'b1, OFS_CTRL, 32'h00073305);
		tick(3);
		apb(1'b0, OFS_STATUS, 0);
		chk("absent", 0, rdat & 32'h30);
		present <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h00073004);
		apb(1'b1, OFS_CTRL, 32'h00073005);
		tick(25);
		apb(1'b0, OFS_STATUS, 0);
		chk("timer run", 32'h20, rdat & 32'h60);
		tick(30);
		apb(1'b0, OFS_STATUS, 0);
		chk("timer fault", 32'h40, rdat & 32'h60);
		chk("fault open", 0, sw);
		chk("fault sys", 4225, sys_t);
		apb(1'b1, OFS_CTRL, 32'h00073704);
		apb(1'b1, OFS_CTRL, 32'h00073705);
		tick(200);
		apb(1'b0, OFS_STATUS, 0);
		chk("timer off", 32'h20, rdat & 32'h60);
		// charge current: setting, input headroom, foldback, dropout walk
		c = {$random(seed)} % 64;
		ld = {$random(seed)} % 2000;
		e = ((c > 60) ? 60 : c) * 50;
		apb(1'b1, OFS_LIMITS, 32'h0018005A | (c << 8));
		iload <= 13'(ld);
		tick(3);
		chk("chg", (e < 3000 - ld) ? e : 3000 - ld, chg_t);
		dtemp <= 8'h78;
		tick(3);
		apb(1'b0, OFS_STATUS, 0);
		chk("foldback", 32'h100, rdat & 32'h100);
		chk("chg fold", (e / 2 < 3000 - ld) ? e / 2 : 3000 - ld, chg_t);
		dtemp <= 8'h19;
		ad_mv <= 14'h1068;
		tick(3100);
		chk("chg drop", 0, chg_t);
		ad_mv <= 14'h1388;
		tick(3100);
		chk("chg back", (e < 3000 - ld) ? e : 3000 - ld, chg_t);
		done <= 1'b1;
		tick(3);
		chk("done chg", 0, chg_t);
		chk("done sw", 0, sw);
		chk("done sys", 4225, sys_t);
		done <= 1'b0;
		iload <= 13'h0;
		// reset in mid-run brings back the defaults
		rstn <= 1'b0;
		tick(2);
		rstn <= 1'b1;
		tick(3);
		chk("ilim rst", 500, ilim);
		chk_path(0, 1, 0);
		results();
	end

	// watchdog well beyond the expected run of about seven thousand cycles
	initial begin
		tick(20000);
		n_fail++;
		results();
	end
endmodule
